/* rtl/pes_status.sv */
// module: program/erase status register of the flash controller
// Contract
// - bit 7 is 0 busy, 1 ready
// - after suspend bit 7 stays 0 until paused
// - status drives the low data lanes on read
// - bit 6 set while erase is suspended
// - resume clears bit 6
// - suspend may finish the operation instead
// - bit 5 set on erase verify failure
// - bit 4 set on program verify failure
// - supply sampled only at operation start
// - bit 3 set when sampled supply below lockout
// - bits 5, 4, 3 sticky until clear or reset
// - pending error makes new operation fail
// - bit 2 set while program is suspended
// - resume clears bit 2
// - bit 1 set on protected block attempt
// - bit 1 sticky until clear or reset
// - bit 0 reserved, reads zero
`timescale 1ns/100ps

module pes_status
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire pes_cmd_t cmd,
    input wire pes_result_t result,
    input wire logic program_supply_lockout_level,
    input wire logic status_read,
    output logic [7:0] low_data_lanes,
    output logic low_data_lanes_oe_n,
    output logic engine_go,
    output logic engine_pause,
    output logic [7:0] status
);

    // ------------------------------------------------------------
    // state and flags
    // ------------------------------------------------------------
    pes_state_t state; // controller state
    logic op_erase; // running operation is an erase
    logic ers_susp; // erase suspended flag
    logic prg_susp; // program suspended flag
    logic ers_err; // sticky erase error
    logic prg_err; // sticky program error
    logic supply_err; // sticky supply error
    logic prot_err; // sticky protection error
    logic supply_low; // supply latched at start
    logic pause_done; // suspend latency expired
    logic any_err; // some error bit still set
    logic start_ok; // start that really runs
    logic start_fail; // start that fails at once
    logic finish; // operation finished now

    assign any_err = ers_err | prg_err | supply_err | prot_err;

    // a start is only honoured from idle
    assign start_ok = cmd.start && state == PES_ST_IDLE && !any_err
        && !cmd.block_protected && !program_supply_lockout_level;
    assign start_fail = cmd.start && state == PES_ST_IDLE && !start_ok;

    // the engine may finish during the pause window
    assign finish = result.done
        && (state == PES_ST_RUN || state == PES_ST_PAUSING);

    // ------------------------------------------------------------
    // suspend latency timer
    // ------------------------------------------------------------
    pes_suspend_timer u_timer
    (
        .clk(clk),
        .rst_n(rst_n),
        .load(cmd.suspend && state == PES_ST_RUN),
        .abort(finish),
        .expired(pause_done)
    );

    // ------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------
    // busy and ready states
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PES_ST_IDLE;
        end
        else
        begin
            case (state)
                PES_ST_IDLE:
                begin
                    if (start_ok)
                        state <= PES_ST_RUN;
                end
                PES_ST_RUN:
                begin
                    if (result.done)
                        state <= PES_ST_IDLE;
                    else if (cmd.suspend)
                        state <= PES_ST_PAUSING;
                end
                PES_ST_PAUSING:
                begin
                    if (result.done)
                        state <= PES_ST_IDLE;
                    else if (pause_done)
                        state <= PES_ST_SUSPENDED;
                end
                PES_ST_SUSPENDED:
                begin
                    if (cmd.resume)
                        state <= PES_ST_RUN;
                end
                default:
                begin
                    state <= PES_ST_IDLE;
                end
            endcase
        end
    end

    // remember which kind of operation is in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            op_erase <= 1'b0;
        else if (start_ok)
            op_erase <= cmd.is_erase;
    end

    // engine strobes: go on start or resume, pause held while suspended
    assign engine_go = start_ok
        || (state == PES_ST_SUSPENDED && cmd.resume);
    assign engine_pause = (state == PES_ST_SUSPENDED);

    // ------------------------------------------------------------
    // supply sampling
    // ------------------------------------------------------------
    // latched once per start
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            supply_low <= 1'b0;
        else if (cmd.start && state == PES_ST_IDLE)
            supply_low <= program_supply_lockout_level;
    end

    // ------------------------------------------------------------
    // suspend flags
    // ------------------------------------------------------------
    // erase suspend flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ers_susp <= 1'b0;
        else if (state == PES_ST_SUSPENDED && cmd.resume)
            ers_susp <= 1'b0;
        else if (state == PES_ST_PAUSING && pause_done && !result.done)
            ers_susp <= op_erase;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prg_susp <= 1'b0;
        else if (state == PES_ST_SUSPENDED && cmd.resume)
            prg_susp <= 1'b0;
        else if (state == PES_ST_PAUSING && pause_done && !result.done)
            prg_susp <= !op_erase;
    end

    // ------------------------------------------------------------
    // sticky error flags; a new set beats a clear in the same cycle
    // ------------------------------------------------------------
    // erase verify error
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ers_err <= 1'b0;
        // set only on finish or failed start
        else if ((finish && op_erase && result.verify_fail)
            || (start_fail && cmd.is_erase))
            ers_err <= 1'b1;
        else if (cmd.clear_status)
            ers_err <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prg_err <= 1'b0;
        else if ((finish && !op_erase && result.verify_fail)
            || (start_fail && !cmd.is_erase))
            prg_err <= 1'b1;
        else if (cmd.clear_status)
            prg_err <= 1'b0;
    end

    // supply lockout error, from the start sample
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            supply_err <= 1'b0;
        else if (start_fail && program_supply_lockout_level)
            supply_err <= 1'b1;
        else if (cmd.clear_status)
            supply_err <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prot_err <= 1'b0;
        else if (cmd.start && state == PES_ST_IDLE && cmd.block_protected)
            prot_err <= 1'b1;
        else if (cmd.clear_status)
            prot_err <= 1'b0;
    end

    // ------------------------------------------------------------
    // register image and read path
    // ------------------------------------------------------------
    // reserved bit fixed
    always_comb
    begin
        status = PES_STATUS_RESET;
        status[PES_BIT_READY] = (state == PES_ST_IDLE)
            || (state == PES_ST_SUSPENDED);
        status[PES_BIT_ERS_SUSP] = ers_susp;
        status[PES_BIT_ERS_ERR] = ers_err;
        status[PES_BIT_PRG_ERR] = prg_err;
        status[PES_BIT_SUPPLY_ERR] = supply_err;
        status[PES_BIT_PRG_SUSP] = prg_susp;
        status[PES_BIT_PROT_ERR] = prot_err;
        status[PES_BIT_RSVD] = PES_RSVD_VALUE;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_data_lanes <= '0;
            low_data_lanes_oe_n <= 1'b1;
        end
        else
        begin
            low_data_lanes <= status_read ? status : 8'h00;
            low_data_lanes_oe_n <= !status_read;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_busy_after_start;
        @(posedge clk) disable iff (!rst_n)
        start_ok |=> !status[PES_BIT_READY];
    endproperty
    a_busy_after_start: assert property (p_busy_after_start)
        else $error("ready still high after start");

    // a finish inside the window may raise ready, an early pause may not
    property p_pause_busy;
        @(posedge clk) disable iff (!rst_n)
        (state == PES_ST_RUN && cmd.suspend && !result.done)
        |=> (!status[PES_BIT_READY] || !(ers_susp || prg_susp)) [*5];
    endproperty
    a_pause_busy: assert property (p_pause_busy)
        else $error("ready rose before pause");

    property p_lanes;
        @(posedge clk) disable iff (!rst_n)
        status_read |=> (low_data_lanes == $past(status)
            && !low_data_lanes_oe_n);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lanes not showing status");

    property p_susp_ready;
        @(posedge clk) disable iff (!rst_n)
        (ers_susp || prg_susp) |-> status[PES_BIT_READY];
    endproperty
    a_susp_ready: assert property (p_susp_ready)
        else $error("suspend flag while busy");

    property p_resume;
        @(posedge clk) disable iff (!rst_n)
        (state == PES_ST_SUSPENDED && cmd.resume)
        |=> !ers_susp && !prg_susp;
    endproperty
    a_resume: assert property (p_resume)
        else $error("suspend flag kept after resume");

    property p_sticky;
        @(posedge clk) disable iff (!rst_n)
        (status[5:3] != 3'b000 && !cmd.clear_status)
        |=> (status[5:3] & $past(status[5:3])) == $past(status[5:3]);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("error bit dropped without clear");

    property p_fail_start;
        @(posedge clk) disable iff (!rst_n)
        (cmd.start && state == PES_ST_IDLE && any_err)
        |=> state == PES_ST_IDLE;
    endproperty
    a_fail_start: assert property (p_fail_start)
        else $error("operation ran with error pending");

    property p_prot;
        @(posedge clk) disable iff (!rst_n)
        (cmd.start && state == PES_ST_IDLE && cmd.block_protected)
        |=> status[PES_BIT_PROT_ERR] && status[PES_BIT_READY];
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected attempt not flagged");

    property p_supply;
        @(posedge clk) disable iff (!rst_n)
        (cmd.start && state == PES_ST_IDLE && program_supply_lockout_level)
        |=> status[PES_BIT_SUPPLY_ERR] && supply_low;
    endproperty
    a_supply: assert property (p_supply)
        else $error("low supply start not flagged");

    property p_rsvd;
        @(posedge clk) disable iff (!rst_n)
        status_read |=> !low_data_lanes[PES_BIT_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");

endmodule // pes_status

/* inc/pes_pkg.sv */
// package: status register layout, events and timing for the status block
package pes_pkg;

    // ------------------------------------------------------------
    // status register field positions
    // ------------------------------------------------------------
    localparam int PES_BIT_READY = 7; // controller idle or suspended when 1
    localparam int PES_BIT_ERS_SUSP = 6; // erase suspended
    localparam int PES_BIT_ERS_ERR = 5; // erase verify failure
    localparam int PES_BIT_PRG_ERR = 4; // program verify failure
    localparam int PES_BIT_SUPPLY_ERR = 3; // supply below lockout
    localparam int PES_BIT_PRG_SUSP = 2; // program suspended
    localparam int PES_BIT_PROT_ERR = 1; // protected block attempt
    localparam int PES_BIT_RSVD = 0; // reserved, reads zero

    // reset values
    localparam logic [7:0] PES_STATUS_RESET = 8'h80;
    localparam logic PES_RSVD_VALUE = 1'b0;

    // time from suspend request to a pause, in ns, and in cycles at 50 MHz
    localparam int PES_CLK_NS = 20;
    localparam int PES_SUSP_LAT_NS = 100;
    localparam int PES_SUSP_LAT_CYC =
        (PES_SUSP_LAT_NS + PES_CLK_NS - 1) / PES_CLK_NS;
    localparam int PES_CNT_W = 8;

    // ------------------------------------------------------------
    // operation kinds and controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PES_OP_PROGRAM = 2'b01,
        PES_OP_ERASE = 2'b10
    } pes_op_t;

    typedef enum logic [3:0]
    {
        PES_ST_IDLE = 4'b0001,
        PES_ST_RUN = 4'b0010,
        PES_ST_PAUSING = 4'b0100,
        PES_ST_SUSPENDED = 4'b1000
    } pes_state_t;

    // command strobes from the command decoder, one-cycle pulses
    typedef struct packed
    {
        logic start; // program or erase begins
        logic is_erase; // 1 erase, 0 program
        logic block_protected; // target block is protected
        logic suspend; // suspend request
        logic resume; // resume request
        logic clear_status; // clear-status command
    } pes_cmd_t;

    // outcome report from the array engine
    typedef struct packed
    {
        logic done; // one-cycle pulse, operation finished
        logic verify_fail; // with done: verify failed
    } pes_result_t;

endpackage : pes_pkg

/* rtl/pes_suspend_timer.sv */
// module: down-counter that times a suspend request to the pause point
`timescale 1ns/100ps

module pes_suspend_timer
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic abort,
    output logic expired
);

    // ------------------------------------------------------------
    // latency counter
    // ------------------------------------------------------------
    logic [PES_CNT_W-1:0] count; // cycles left
    logic running; // counting in progress

    // load restarts the count; abort drops it silently
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            running <= 1'b0;
        end
        else if (abort)
        begin
            running <= 1'b0;
        end
        else if (load)
        begin
            count <= PES_CNT_W'(PES_SUSP_LAT_CYC - 1);
            running <= 1'b1;
        end
        else if (running && count == '0)
        begin
            running <= 1'b0;
        end
        else if (running)
        begin
            count <= count - 1'b1;
        end
    end

    // pulse on the last counted cycle
    assign expired = running && (count == '0) && !abort;

endmodule // pes_suspend_timer

/* testbench/pes_engine_model.sv */
// partner model: array engine that runs, pauses and reports operations
`timescale 1ns/100ps

module pes_engine_model
    import pes_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic engine_go,
    input wire logic engine_pause,
    input wire logic [7:0] run_cycles,
    input wire logic fail_next,
    output pes_result_t result
);
    // ------------------------------------------------------------
    // operation timer
    // ------------------------------------------------------------
    logic [7:0] remaining; // cycles left, held while suspended

    // fresh start loads the count, resume keeps the leftover
    // finish may still land while pausing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            remaining <= 8'h00;
            result <= '0;
        end
        else
        begin
            // done is a one-cycle pulse, verdict only beside it
            result <= '0;
            if (engine_go && remaining == 8'h00)
            begin
                remaining <= run_cycles;
            end
            else if (!engine_pause && remaining == 8'h01)
            begin
                remaining <= 8'h00;
                result.done <= 1'b1;
                result.verify_fail <= fail_next;
            end
            else if (!engine_pause && remaining != 8'h00)
            begin
                remaining <= remaining - 8'h01;
            end
        end
    end
endmodule // pes_engine_model

/* testbench/flash_program_erase_status_test.sv */
// testbench: command sequences against the status register block
`timescale 1ns/100ps

module flash_program_erase_status_test;
    import pes_pkg::*;

    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    localparam logic [5:0] PRG = 6'h20; // start program
    localparam logic [5:0] ERS = 6'h30; // start erase
    localparam logic [5:0] PRG_PROT = 6'h28; // program, protected block
    localparam logic [5:0] SUSP = 6'h04; // suspend request
    localparam logic [5:0] RES = 6'h02; // resume request
    localparam logic [5:0] CLR = 6'h01; // clear-status

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pes_cmd_t cmd = '0;
    pes_result_t result;
    logic lockout = 1'b0; // 1 = supply below lockout
    logic status_read = 1'b0;
    logic [7:0] run_cycles = 8'h08; // engine run length
    logic fail_next = 1'b0; // next finish reports a verify failure
    logic [7:0] low_data_lanes;
    logic low_data_lanes_oe_n;
    logic engine_go;
    logic engine_pause;
    logic [7:0] status;
    int error_cnt = 0;
    int checks = 0;

    always #10 clk = ~clk;

    pes_status DUT (
        .clk(clk),
        .rst_n(rst_n),
        .cmd(cmd),
        .result(result),
        .program_supply_lockout_level(lockout),
        .status_read(status_read),
        .low_data_lanes(low_data_lanes),
        .low_data_lanes_oe_n(low_data_lanes_oe_n),
        .engine_go(engine_go),
        .engine_pause(engine_pause),
        .status(status)
    );

    pes_engine_model engine (
        .clk(clk),
        .rst_n(rst_n),
        .engine_go(engine_go),
        .engine_pause(engine_pause),
        .run_cycles(run_cycles),
        .fail_next(fail_next),
        .result(result)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle command pulse, returns with its effect visible
    task automatic issue(input logic [5:0] c);
        @(negedge clk);
        cmd = pes_cmd_t'(c);
        @(negedge clk);
        cmd = '0;
    endtask

    // bounded poll of the ready bit, as a host would
    task automatic wait_ready();
        int n;
        n = 0;
        while (status[7] !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 500)
        begin
            error_cnt++;
            $display("[ERR] ready wait expected 1 seen %b", status[7]);
        end
    endtask

    // read cycle over the low lanes, driver released afterwards
    task automatic read_lanes(input logic [7:0] exp);
        @(negedge clk);
        status_read = 1'b1;
        @(negedge clk);
        chk("lanes", exp, low_data_lanes);
        chk("lanes oe_n", 8'h00, {7'h00, low_data_lanes_oe_n});
        status_read = 1'b0;
        @(negedge clk);
        chk("lanes oe_n off", 8'h01, {7'h00, low_data_lanes_oe_n});
    endtask

    task automatic reset_dut();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
    endtask

    // suspend two cycles into a run, pause, hold, then resume
    task automatic susp_seq(input logic [5:0] op, input logic [7:0] img);
        run_cycles = 8'h40;
        issue(op);
        issue(SUSP);
        chk("pausing", 8'h00, status & 8'h80);
        repeat (4)
        begin
            @(negedge clk);
            chk("pausing", 8'h00, status & 8'h80);
        end
        @(negedge clk);
        chk("suspended", img, status);
        repeat (20) @(negedge clk);
        chk("suspend held", img, status);
        issue(RES);
        chk("resumed", 8'h00, status);
        wait_ready();
        chk("resume done", 8'h80, status);
    endtask

    task give_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog, far beyond the few hundred cycles the run needs
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[ERR] watchdog expected end seen hang");
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_dut();
        chk("reset image", 8'h80, status);
        chk("lanes idle", 8'h00, low_data_lanes);
        read_lanes(8'h80);
        issue(PRG);
        chk("busy", 8'h00, status);
        wait_ready();
        chk("program ok", 8'h80, status);
        issue(ERS);
        wait_ready();
        chk("erase ok", 8'h80, status);
        fail_next = 1'b1;
        issue(PRG);
        wait_ready();
        fail_next = 1'b0;
        chk("program fail", 8'h90, status);
        read_lanes(8'h90);
        issue(ERS);
        chk("start with error", 8'hb0, status);
        repeat (20) @(negedge clk);
        chk("sticky", 8'hb0, status);
        issue(CLR);
        chk("cleared", 8'h80, status);
        fail_next = 1'b1;
        issue(ERS);
        wait_ready();
        fail_next = 1'b0;
        chk("erase fail", 8'ha0, status);
        issue(CLR);
        issue(PRG_PROT);
        chk("protected", 8'h92, status);
        repeat (10) @(negedge clk);
        chk("protect sticky", 8'h92, status);
        issue(CLR);
        chk("protect clear", 8'h80, status);
        lockout = 1'b1;
        issue(ERS);
        lockout = 1'b0;
        chk("low supply", 8'ha8, status);
        issue(CLR);
        issue(PRG);
        lockout = 1'b1;
        wait_ready();
        lockout = 1'b0;
        chk("supply mid run", 8'h80, status);
        susp_seq(ERS, 8'hc0);
        susp_seq(PRG, 8'h84);
        issue(SUSP);
        chk("idle suspend", 8'h80, status);
        run_cycles = 8'h04;
        issue(ERS);
        issue(SUSP);
        wait_ready();
        chk("finish wins", 8'h80, status);
        run_cycles = 8'h40;
        issue(PRG);
        reset_dut();
        chk("reset in run", 8'h80, status);
        issue(PRG_PROT);
        reset_dut();
        chk("reset clears", 8'h80, status);
        give_verdict();
    end
endmodule // flash_program_erase_status_test
